// File: framer_error_timer_irq_status.sv
// Error, counter overflow and timer interrupt status registers of one framer
`timescale 1ns/10ps
module framer_error_timer_irq_status (
  input wire logic clock, // System clock
  input wire logic rst, // Sync reset, active high
  input wire logic [8:0] addr, // Processor register address
  input wire logic rdStb, // Read strobe, one cycle
  input wire logic wrStb, // Write strobe, one cycle
  input wire logic [7:0] wrData, // Write data
  output logic [7:0] rdData_r, // Read data, valid cycle after strobe
  output logic irqReq_r, // Interrupt request, active high
  input wire irq_status_pkg::error_src_t errSrc, // Error sources
  input wire irq_status_pkg::overflow_src_t ovfSrc, // Counters at maximum
  input wire irq_status_pkg::timer_src_t tmrSrc, // Timer event sources
  input wire irq_status_pkg::frame_mode_t mode, // Framing mode
  input wire logic txPhase, // Transmit slip buffer half
  input wire logic rxPhase // Receive slip buffer half
);
  import irq_status_pkg::*;

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] errEnable_r;
  logic [7:0] ovfEnable_r;
  logic [7:0] tmrEnable_r;
  logic [7:0] latchCtrl_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      errEnable_r <= REG_RESET;
      ovfEnable_r <= REG_RESET;
      tmrEnable_r <= REG_RESET;
      latchCtrl_r <= REG_RESET;
    end else if (wrStb) begin
      case (addr)
        ERROR_IRQ_ENABLE_ADDR: errEnable_r <= wrData;
        OVERFLOW_IRQ_ENABLE_ADDR: ovfEnable_r <= wrData;
        TIMER_IRQ_ENABLE_ADDR: tmrEnable_r <= wrData;
        LATCH_CONTROL_ADDR: latchCtrl_r <= wrData; // RULE20
        default: ;
      endcase
    end
  end

  property p_latch_write;
    @(posedge clock) disable iff (rst) (wrStb && addr == LATCH_CONTROL_ADDR) |=> (latchCtrl_r == $past(wrData));
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch control write lost"); // RULE20

  // ****************************************
  // Error event status
  // ****************************************
  logic latchErr;
  logic [7:0] errLevel;
  logic [7:0] errStat;
  logic [7:0] errClr;
  logic [7:0] errAllow;
  logic rdErr;
  logic rdOvf;
  logic rdTmr;
  logic rdSlip;

  assign rdErr = rdStb && (addr == ERROR_EVENT_STATUS_ADDR);
  assign rdOvf = rdStb && (addr == COUNTER_OVERFLOW_STATUS_ADDR);
  assign rdTmr = rdStb && (addr == FRAME_TIMER_STATUS_ADDR);
  assign rdSlip = rdStb && (addr == SLIP_DETAIL_STATUS_ADDR);
  assign latchErr = latchCtrl_r[LATCH_ERR_BIT]; // RULE20

  assign errLevel = {
    errSrc.txFullSlip | errSrc.txUncontrolledSlip, // RULE3
    errSrc.rxFullSlip | errSrc.rxUncontrolledSlip, // RULE4
    2'b00,
    errSrc.crcBlockError & mode.crcMode, // RULE5
    errSrc.casPatternError & mode.e1Mode, // RULE6
    errSrc.mfAlignError & mode.e1Mode, // RULE7
    errSrc.framingPatternError
  };
  // Latched: held to read; unlatched: bit drops next cycle, so a read sees a live pulse only
  assign errClr = latchErr ? {8{rdErr}} : 8'hFF; // RULE1
  // Mode-gated bits also clear when the mode leaves so they read zero
  assign errAllow = ERR_USED_MASK & {2'b11, 2'b00, mode.crcMode, mode.e1Mode, mode.e1Mode, 1'b1};

  rise_latch #(.WIDTH(8)) errLatch (
    .clock(clock),
    .rst(rst),
    .src(errLevel),
    .allow(errAllow),
    .clr(errClr | ~errAllow),
    .stat(errStat)
  ); // RULE1

  property p_err_held;
    @(posedge clock) disable iff (rst) (latchErr && errStat[0] && !rdErr) |=> errStat[0];
  endproperty
  a_err_held: assert property (p_err_held) else $error("latched error bit dropped without read"); // RULE1

  // Only after a full unlatched cycle, so a bit held across the switch is not blamed
  property p_err_pulse;
    @(posedge clock) disable iff (rst) (!latchErr && !$past(latchErr) && errStat[0]) |=> !errStat[0];
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("unlatched error bit was held"); // RULE20

  property p_crc_set;
    @(posedge clock) disable iff (rst) (mode.crcMode && $rose(errSrc.crcBlockError)) |=> errStat[3];
  endproperty
  a_crc_set: assert property (p_crc_set) else $error("crc block error not latched"); // RULE5

  property p_mfa_set;
    @(posedge clock) disable iff (rst) (mode.e1Mode && $rose(errSrc.mfAlignError)) |=> errStat[1];
  endproperty
  a_mfa_set: assert property (p_mfa_set) else $error("multiframe alignment error not latched"); // RULE7

  property p_rx_slip_set;
    @(posedge clock) disable iff (rst) ($rose(errSrc.rxFullSlip) && !errSrc.rxUncontrolledSlip
      && !$past(errSrc.rxUncontrolledSlip)) |=> errStat[6];
  endproperty
  a_rx_slip_set: assert property (p_rx_slip_set) else $error("receive slip not latched"); // RULE4

  logic [3:0] slipDetail;

  slip_detail slipKinds (
    .clock(clock),
    .rst(rst),
    .slipSrc({errSrc.rxUncontrolledSlip, errSrc.rxFullSlip, errSrc.txUncontrolledSlip, errSrc.txFullSlip}),
    .rdClr(rdSlip),
    .detail(slipDetail)
  ); // RULE3 RULE4

  property p_slip_kind_tx;
    @(posedge clock) disable iff (rst) $rose(errSrc.txUncontrolledSlip) |=> slipDetail[1];
  endproperty
  a_slip_kind_tx: assert property (p_slip_kind_tx) else $error("transmit slip kind not recorded"); // RULE3

  property p_slip_kind_rx;
    @(posedge clock) disable iff (rst) $rose(errSrc.rxFullSlip) |=> slipDetail[2];
  endproperty
  a_slip_kind_rx: assert property (p_slip_kind_rx) else $error("receive slip kind not recorded"); // RULE4

  // ****************************************
  // Counter overflow status
  // ****************************************
  logic [7:0] ovfStat;

  rise_latch #(.WIDTH(8)) ovfLatch (
    .clock(clock),
    .rst(rst),
    .src(ovfSrc), // RULE10
    .allow(ovfEnable_r), // RULE8
    .clr({8{rdOvf}}), // RULE9
    .stat(ovfStat)
  );

  property p_ovf_set;
    @(posedge clock) disable iff (rst) (ovfEnable_r[7] && $rose(ovfSrc.outOfFrameCount)) |=> ovfStat[7];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("enabled overflow not latched"); // RULE8 RULE10

  property p_ovf_irq;
    @(posedge clock) disable iff (rst) ((ovfStat & ovfEnable_r) != 8'h00) |=> irqReq_r;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("enabled overflow gave no irq"); // RULE9

  // ****************************************
  // Frame timer status
  // ****************************************
  logic [7:0] tmrStat;

  // Each timer event except the receive signaling stack event is a multiframe/frame start pulse from the framers
  rise_latch #(.WIDTH(8)) tmrLatch (
    .clock(clock),
    .rst(rst),
    .src(tmrSrc), // RULE12 RULE13 RULE14 RULE15 RULE17 RULE18 RULE19
    .allow(8'hFF),
    .clr({8{rdTmr}}), // RULE11 RULE16
    .stat(tmrStat)
  );

  property p_tmr_hold;
    @(posedge clock) disable iff (rst) (tmrStat[0] && !rdTmr) |=> tmrStat[0];
  endproperty
  a_tmr_hold: assert property (p_tmr_hold) else $error("timer bit dropped without read"); // RULE11

  property p_tx_signaling_mf_event_set;
    @(posedge clock) disable iff (rst) $rose(tmrSrc.txSignalingMfEvent) |=> tmrStat[7];
  endproperty
  a_tx_signaling_mf_event_set: assert property (p_tx_signaling_mf_event_set) else $error("transmit signaling event lost"); // RULE12

  property p_tx_sysbus_mf_sync_set;
    @(posedge clock) disable iff (rst) $rose(tmrSrc.txSysbusMfSync) |=> tmrStat[6];
  endproperty
  a_tx_sysbus_mf_sync_set: assert property (p_tx_sysbus_mf_sync_set) else $error("transmit bus sync event lost"); // RULE13

  property p_tmf_set;
    @(posedge clock) disable iff (rst) $rose(tmrSrc.txMultiframeEvent) |=> tmrStat[5];
  endproperty
  a_tmf_set: assert property (p_tmf_set) else $error("transmit multiframe event lost"); // RULE14

  property p_rx_signaling_stack_event_set;
    @(posedge clock) disable iff (rst) $rose(tmrSrc.rxSignalingStackEvent) |=> tmrStat[3];
  endproperty
  a_rx_signaling_stack_event_set: assert property (p_rx_signaling_stack_event_set) else $error("receive signaling event lost"); // RULE16

  property p_rx_sysbus_mf_sync_set;
    @(posedge clock) disable iff (rst) $rose(tmrSrc.rxSysbusMfSync) |=> tmrStat[2];
  endproperty
  a_rx_sysbus_mf_sync_set: assert property (p_rx_sysbus_mf_sync_set) else $error("receive bus sync event lost"); // RULE17

  property p_rmf_set;
    @(posedge clock) disable iff (rst) $rose(tmrSrc.rxMultiframeEvent) |=> tmrStat[1];
  endproperty
  a_rmf_set: assert property (p_rmf_set) else $error("receive multiframe event lost"); // RULE18

  property p_rx_frame_event_set;
    @(posedge clock) disable iff (rst) $rose(tmrSrc.rxFrameEvent) |=> tmrStat[0];
  endproperty
  a_rx_frame_event_set: assert property (p_rx_frame_event_set) else $error("receive frame event lost"); // RULE19

  // ****************************************
  // Read port and interrupt
  // ****************************************
  logic [7:0] rdMux;

  always_comb begin
    rdMux = 8'h00;
    case (addr)
      ERROR_EVENT_STATUS_ADDR: rdMux = errStat;
      COUNTER_OVERFLOW_STATUS_ADDR: rdMux = ovfStat;
      FRAME_TIMER_STATUS_ADDR: rdMux = tmrStat;
      ERROR_IRQ_ENABLE_ADDR: rdMux = errEnable_r;
      OVERFLOW_IRQ_ENABLE_ADDR: rdMux = ovfEnable_r;
      TIMER_IRQ_ENABLE_ADDR: rdMux = tmrEnable_r;
      LATCH_CONTROL_ADDR: rdMux = latchCtrl_r;
      SLIP_DETAIL_STATUS_ADDR: rdMux = {4'h0, slipDetail};
      TX_PHASE_ADDR: rdMux = {6'h00, rxPhase, txPhase}; // RULE15 RULE19
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdData_r <= REG_RESET;
    end else if (rdStb) begin
      rdData_r <= rdMux;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irqReq_r <= 1'b0;
    end else begin
      irqReq_r <= |(errStat & errEnable_r) | |(ovfStat & ovfEnable_r) | |(tmrStat & tmrEnable_r); // RULE2 RULE21
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_err_irq_gated;
    @(posedge clock) disable iff (rst) (errStat != 8'h00 && (errStat & errEnable_r) == 8'h00
      && (ovfStat & ovfEnable_r) == 8'h00 && (tmrStat & tmrEnable_r) == 8'h00) |=> !irqReq_r;
  endproperty
  a_err_irq_gated: assert property (p_err_irq_gated) else $error("irq without enabled status"); // RULE2

  property p_irq_any;
    @(posedge clock) disable iff (rst) ((tmrStat & tmrEnable_r) != 8'h00) |=> irqReq_r;
  endproperty
  a_irq_any: assert property (p_irq_any) else $error("enabled timer status gave no irq"); // RULE21

  property p_crc_zero;
    @(posedge clock) disable iff (rst) !mode.crcMode |=> !errStat[3];
  endproperty
  a_crc_zero: assert property (p_crc_zero) else $error("crc error outside crc mode"); // RULE5

  property p_cas_zero;
    @(posedge clock) disable iff (rst) !mode.e1Mode |=> (errStat[2:1] == 2'b00);
  endproperty
  a_cas_zero: assert property (p_cas_zero) else $error("E1 error bit set in T1 mode"); // RULE6

  property p_ovf_masked;
    @(posedge clock) disable iff (rst) (!ovfStat[0] && !ovfEnable_r[0]) |=> !ovfStat[0];
  endproperty
  a_ovf_masked: assert property (p_ovf_masked) else $error("masked overflow was reported"); // RULE8

  property p_ovf_hold;
    @(posedge clock) disable iff (rst) (ovfStat[7] && !rdOvf) |=> ovfStat[7];
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow dropped without read"); // RULE9

  property p_tmr_set;
    @(posedge clock) disable iff (rst) $rose(tmrSrc.txFrameEvent) |=> tmrStat[4];
  endproperty
  a_tmr_set: assert property (p_tmr_set) else $error("transmit frame event lost"); // RULE15

  property p_tmr_clear;
    @(posedge clock) disable iff (rst) (rdTmr && !$rose(tmrSrc.rxSignalingStackEvent)) |=> !tmrStat[3];
  endproperty
  a_tmr_clear: assert property (p_tmr_clear) else $error("signaling bit survived read"); // RULE16

  property p_slip_set;
    @(posedge clock) disable iff (rst) ($rose(errSrc.txFullSlip) && !errSrc.txUncontrolledSlip
      && !$past(errSrc.txUncontrolledSlip) && latchErr) |=> errStat[7];
  endproperty
  a_slip_set: assert property (p_slip_set) else $error("transmit slip not latched"); // RULE3

  property p_err_irq;
    @(posedge clock) disable iff (rst) ((errStat & errEnable_r) != 8'h00) |=> irqReq_r;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("enabled error status gave no irq"); // RULE2

  property p_irq_quiet;
    @(posedge clock) disable iff (rst) ((errStat & errEnable_r) == 8'h00 && (ovfStat & ovfEnable_r) == 8'h00
      && (tmrStat & tmrEnable_r) == 8'h00) |=> !irqReq_r;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq with no enabled status"); // RULE21
endmodule

// File: irq_status_pkg.sv
// Package with register map, field layout and carrier types of the interrupt status block
// Function
// [RULE1] Error bits set on rising edge, latch-controlled hold
// [RULE2] Error interrupt only when matching enable set
// [RULE3] Transmit slip bit for full or uncontrolled
// [RULE4] Receive slip bit for full or uncontrolled
// [RULE5] CRC block error only in ESF/MFAS
// [RULE6] CAS pattern error only in E1 mode
// [RULE7] Multiframe alignment error only in E1
// [RULE8] Overflow latched only while its enable set
// [RULE9] Overflow bits held until status read clears
// [RULE10] Overflow bits map to eight error counters
// [RULE11] Timer bits rising edge, read clears, enabled interrupt
// [RULE12] Transmit signaling multiframe start event
// [RULE13] Transmit system bus multiframe sync event
// [RULE14] Transmit multiframe start event
// [RULE15] Transmit frame start event, phase readable
// [RULE16] New receive signaling, cleared on timer read
// [RULE17] Receive system bus multiframe sync event
// [RULE18] Receive multiframe boundary event
// [RULE19] Receive frame start event, phase readable
// [RULE20] Latch control register selects held status
// [RULE21] Interrupt while any enabled status bit set
package irq_status_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [8:0] ERROR_EVENT_STATUS_ADDR = 9'h006;
  localparam logic [8:0] COUNTER_OVERFLOW_STATUS_ADDR = 9'h007;
  localparam logic [8:0] FRAME_TIMER_STATUS_ADDR = 9'h008;
  localparam logic [8:0] ERROR_IRQ_ENABLE_ADDR = 9'h00E;
  localparam logic [8:0] OVERFLOW_IRQ_ENABLE_ADDR = 9'h00F;
  localparam logic [8:0] TIMER_IRQ_ENABLE_ADDR = 9'h010;
  localparam logic [8:0] LATCH_CONTROL_ADDR = 9'h046;
  localparam logic [8:0] SLIP_DETAIL_STATUS_ADDR = 9'h0D9;
  localparam logic [8:0] TX_PHASE_ADDR = 9'h0DC;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int LATCH_ERR_BIT = 1;
  localparam int SLIP_TX_FULL_BIT = 0;
  localparam int SLIP_TX_UNCTRL_BIT = 1;
  localparam int SLIP_RX_FULL_BIT = 2;
  localparam int SLIP_RX_UNCTRL_BIT = 3;
  localparam int RX_PHASE_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ERR_USED_MASK = 8'hCF;

  // Error sources; the full and uncontrolled slip levels of each direction share one status bit
  typedef struct packed {
    logic txFullSlip;
    logic txUncontrolledSlip;
    logic rxFullSlip;
    logic rxUncontrolledSlip;
    logic crcBlockError;
    logic casPatternError;
    logic mfAlignError;
    logic framingPatternError;
  } error_src_t;

  // Timer sources in status bit order 7..0
  typedef struct packed {
    logic txSignalingMfEvent;
    logic txSysbusMfSync;
    logic txMultiframeEvent;
    logic txFrameEvent;
    logic rxSignalingStackEvent;
    logic rxSysbusMfSync;
    logic rxMultiframeEvent;
    logic rxFrameEvent;
  } timer_src_t;

  // Counter-at-maximum levels in status bit order 7..0
  typedef struct packed {
    logic outOfFrameCount;
    logic alignmentChangeCount;
    logic severeFrameCount;
    logic testPatternBitErrorCount;
    logic febeCount;
    logic lcvCount;
    logic crcCount;
    logic framingPatternErrorCount;
  } overflow_src_t;

  typedef struct packed {
    logic e1Mode;
    logic crcMode;
  } frame_mode_t;
endpackage

// File: rise_latch.sv
// Rising edge detect with sticky latch, set winning over clear
`timescale 1ns/10ps
module rise_latch #(
  parameter int WIDTH = 8
) (
  input wire logic clock, // System clock
  input wire logic rst, // Sync reset
  input wire logic [WIDTH-1:0] src, // Source levels
  input wire logic [WIDTH-1:0] allow, // Per-bit set allow
  input wire logic [WIDTH-1:0] clr, // Per-bit clear
  output logic [WIDTH-1:0] stat // Latched status
);
  logic [WIDTH-1:0] srcPrev_r;
  logic [WIDTH-1:0] rise;

  assign rise = src & ~srcPrev_r & allow;

  always_ff @(posedge clock) begin
    if (rst) begin
      srcPrev_r <= '0;
    end else begin
      srcPrev_r <= src;
    end
  end

  // A new edge in the clear cycle survives
  always_ff @(posedge clock) begin
    if (rst) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~clr) | rise;
    end
  end
endmodule

// File: slip_detail.sv
// Slip kind detail register, latched per kind, cleared on read
`timescale 1ns/10ps
module slip_detail (
  input wire logic clock, // System clock
  input wire logic rst, // Sync reset
  input wire logic [3:0] slipSrc, // Slip kind levels
  input wire logic rdClr, // Read of detail register
  output logic [3:0] detail // Latched kinds
);
  logic [3:0] prev_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      prev_r <= '0;
      detail <= '0;
    end else begin
      prev_r <= slipSrc;
      detail <= (detail & ~{4{rdClr}}) | (slipSrc & ~prev_r);
    end
  end
endmodule

// File: testbench.sv
// Self-checking testbench for the framer error, overflow and timer interrupt status block
`timescale 1ns/10ps
module testbench;
  import irq_status_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [8:0] addr = 9'h000;
  logic rdStb = 1'b0;
  logic wrStb = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic [7:0] rdData_r;
  logic irqReq_r;
  error_src_t errSrc = '0;
  overflow_src_t ovfSrc = '0;
  timer_src_t tmrSrc = '0;
  frame_mode_t mode = '0;
  logic txPhase = 1'b0;
  logic rxPhase = 1'b0;
  int err_total = 0;
  int comparisons = 0;

  always #2 clock = ~clock;

  framer_error_timer_irq_status uut (
    .clock(clock), .rst(rst), .addr(addr), .rdStb(rdStb), .wrStb(wrStb), .wrData(wrData),
    .rdData_r(rdData_r), .irqReq_r(irqReq_r), .errSrc(errSrc), .ovfSrc(ovfSrc), .tmrSrc(tmrSrc),
    .mode(mode), .txPhase(txPhase), .rxPhase(rxPhase)
  );

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp);
    comparisons++;
    if (irqReq_r !== exp) begin
      err_total++;
      $display("BAD %s expected %b seen %b", what, exp, irqReq_r);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clock);
    wrStb <= 1'b0;
  endtask
  task automatic rdChk(input string what, input logic [8:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    #1 chk8(what, exp, rdData_r);
  endtask
  // Sources are raised for two cycles, then dropped so the next rise is a true edge
  task automatic rise(input int which, input logic [7:0] v);
    @(posedge clock);
    if (which == 0) errSrc <= v;
    else if (which == 1) ovfSrc <= v;
    else tmrSrc <= v;
    repeat (2) @(posedge clock);
    errSrc <= '0;
    ovfSrc <= '0;
    tmrSrc <= '0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset;
    rdChk("error status", ERROR_EVENT_STATUS_ADDR, REG_RESET);
    rdChk("overflow status", COUNTER_OVERFLOW_STATUS_ADDR, REG_RESET);
    rdChk("timer status", FRAME_TIMER_STATUS_ADDR, REG_RESET);
    wr(FRAME_TIMER_STATUS_ADDR, 8'hFF);
    rdChk("timer after write", FRAME_TIMER_STATUS_ADDR, 8'h00);
    rdChk("unmapped", 9'h1FF, 8'h00);
    chk1("irq idle", 1'b0);
  endtask
  task automatic test_timer;
    for (int i = 0; i < 8; i++) begin
      rise(2, 8'h01 << i);
      chk1("timer irq masked", 1'b0);
      rdChk("timer bit", FRAME_TIMER_STATUS_ADDR, 8'h01 << i);
      rdChk("timer cleared", FRAME_TIMER_STATUS_ADDR, 8'h00);
    end
    wr(TIMER_IRQ_ENABLE_ADDR, 8'h01);
    rise(2, 8'h02);
    chk1("timer other bit", 1'b0);
    rise(2, 8'h01);
    chk1("timer irq", 1'b1);
    rdChk("timer both", FRAME_TIMER_STATUS_ADDR, 8'h03);
    repeat (2) @(posedge clock);
    #1 chk1("timer irq gone", 1'b0);
    wr(TIMER_IRQ_ENABLE_ADDR, 8'h00);
  endtask
  task automatic test_overflow;
    wr(OVERFLOW_IRQ_ENABLE_ADDR, 8'hA5);
    rise(1, 8'hFF);
    chk1("overflow irq", 1'b1);
    rdChk("overflow masked", COUNTER_OVERFLOW_STATUS_ADDR, 8'hA5);
    rdChk("overflow cleared", COUNTER_OVERFLOW_STATUS_ADDR, 8'h00);
    #1 chk1("overflow irq gone", 1'b0);
    wr(OVERFLOW_IRQ_ENABLE_ADDR, 8'h5A);
    rise(1, 8'hFF);
    rdChk("overflow other half", COUNTER_OVERFLOW_STATUS_ADDR, 8'h5A);
    wr(OVERFLOW_IRQ_ENABLE_ADDR, 8'h00);
  endtask
  task automatic test_error;
    mode <= '{e1Mode: 1'b1, crcMode: 1'b1};
    wr(LATCH_CONTROL_ADDR, 8'h02);
    rise(0, 8'hFF);
    chk1("error irq masked", 1'b0);
    rdChk("error all", ERROR_EVENT_STATUS_ADDR, ERR_USED_MASK);
    rdChk("slip kinds", SLIP_DETAIL_STATUS_ADDR, 8'h0F);
    rdChk("slip cleared", SLIP_DETAIL_STATUS_ADDR, 8'h00);
    wr(ERROR_IRQ_ENABLE_ADDR, 8'h80);
    rise(0, 8'h40);
    chk1("error irq", 1'b1);
    rdChk("tx slip alone", ERROR_EVENT_STATUS_ADDR, 8'h80);
    rdChk("tx underflow kind", SLIP_DETAIL_STATUS_ADDR, 8'h02);
    rise(0, 8'h10);
    chk1("rx slip masked", 1'b0);
    rdChk("rx slip alone", ERROR_EVENT_STATUS_ADDR, 8'h40);
    rdChk("rx underflow kind", SLIP_DETAIL_STATUS_ADDR, 8'h08);
    rise(0, 8'h80);
    chk1("tx full irq", 1'b1);
    rdChk("tx full slip", ERROR_EVENT_STATUS_ADDR, 8'h80);
    rdChk("tx full kind", SLIP_DETAIL_STATUS_ADDR, 8'h01);
    rise(0, 8'h20);
    chk1("rx full masked", 1'b0);
    rdChk("rx full slip", ERROR_EVENT_STATUS_ADDR, 8'h40);
    rdChk("rx full kind", SLIP_DETAIL_STATUS_ADDR, 8'h04);
    @(posedge clock);
    mode <= '{e1Mode: 1'b0, crcMode: 1'b0};
    rise(0, 8'h0F);
    rdChk("t1 no crc", ERROR_EVENT_STATUS_ADDR, 8'h01);
    @(posedge clock);
    mode <= '{e1Mode: 1'b1, crcMode: 1'b0};
    rise(0, 8'h0F);
    rdChk("e1 no crc", ERROR_EVENT_STATUS_ADDR, 8'h07);
    @(posedge clock);
    mode <= '{e1Mode: 1'b0, crcMode: 1'b1};
    rise(0, 8'h0F);
    rdChk("t1 crc", ERROR_EVENT_STATUS_ADDR, 8'h09);
    wr(LATCH_CONTROL_ADDR, 8'h00);
    rise(0, 8'hFF);
    rdChk("error not held", ERROR_EVENT_STATUS_ADDR, 8'h00);
    wr(ERROR_IRQ_ENABLE_ADDR, 8'h00);
  endtask
  task automatic test_phase;
    txPhase <= 1'b1;
    rdChk("tx phase", TX_PHASE_ADDR, 8'h01);
    @(posedge clock);
    txPhase <= 1'b0;
    rxPhase <= 1'b1;
    rdChk("rx phase", TX_PHASE_ADDR, 8'h02);
  endtask

  // ****************************************
  // Verdict and sequence
  // ****************************************
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles, so five thousand means a hang
  initial begin
    #(4 * 5000);
    err_total++;
    results();
  end

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    test_reset();
    test_timer();
    test_overflow();
    test_error();
    test_phase();
    results();
  end
endmodule
